// *** rtl/bcp_i2c_slave.sv ***
// I2C register slave with pointer auto-increment
`timescale 1ns/1ps
`default_nettype none
module bcp_i2c_slave import bcp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output bcp_wr_t wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  bcp_i2c_t st;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  assign start = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop = scl_s[1] && scl_d && !sda_d && sda_s[1];
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= I_IDLE;
      sh <= 8'h00;
      cnt <= 4'h0;
      rd_addr <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr <= '0;
    end else begin
      wr.en <= 1'b0;
      if (start) begin
        st <= I_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (st != I_IDLE && scl_rise) begin
        if (cnt < 4'h8) begin
          sh <= (st == I_RDATA) ? {sh[6:0], 1'b0} : {sh[6:0], sda_s[1]};
          cnt <= cnt + 4'h1;
        end else if (cnt == 4'h8) begin
          cnt <= 4'h9;
          // Master nack ends a read burst
          if (st == I_RDATA && sda_s[1]) begin
            st <= I_IDLE;
          end
        end
      end else if (st != I_IDLE && scl_fall) begin
        if (cnt == 4'h8) begin
          sda_oe <= 1'b0;
          if (st == I_ADDR) begin
            if (sh[7:1] == I2C_ADDR) begin
              sda_oe <= 1'b1;
              st <= sh[0] ? I_RDATA : I_REG;
            end else begin
              st <= I_IDLE;
            end
          end else if (st == I_REG) begin
            sda_oe <= 1'b1;
            rd_addr <= sh;
            st <= I_WDATA;
          end else if (st == I_WDATA) begin
            sda_oe <= 1'b1;
            wr.en <= 1'b1;
            wr.addr <= rd_addr;
            wr.data <= sh;
            rd_addr <= rd_addr + 8'h01;
          end
        end else if (cnt == 4'h9) begin
          cnt <= 4'h0;
          sda_oe <= 1'b0;
          if (st == I_RDATA) begin
            sh <= rd_data;
            sda_oe <= !rd_data[7];
            rd_addr <= rd_addr + 8'h01;
          end
        end else if (st == I_RDATA && cnt != 4'h0) begin
          sda_oe <= !sh[7];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/bcp_pkg.sv ***
// Package: constants, register map and types of the buck control block
package bcp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int SW_FREQ_KHZ = 3000;
  // 10 MHz / 3 MHz does not divide evenly; a longest period rounds down
  localparam int SW_PERIOD_CYC = CLK_KHZ / SW_FREQ_KHZ;
  localparam int RAMP_STEP_US = 10;
  localparam int RAMP_STEP_CYC = RAMP_STEP_US * CLK_KHZ / 1000;
  localparam int SOFT_STEP_CYC = SW_PERIOD_CYC;
  localparam int RETRY_MS = 4;
  localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
  localparam int START_MS = 1;
  localparam int START_CYC = START_MS * CLK_KHZ;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_PG = 8'h01;
  localparam logic [7:0] REG_HIGH = 8'h10;
  localparam logic [7:0] REG_LOW = 8'h11;
  localparam logic [7:0] REG_DISCH = 8'h12;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [7:0] REG_PEAK_CURRENT_LIMIT = 8'h16;
  localparam logic [7:0] REG_EVT = 8'h18;
  localparam logic [7:0] REG_GRP_HIGH = 8'h1C;
  localparam logic [7:0] REG_GRP_LOW = 8'h1D;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ON_BIT = 7;
  localparam int MODE_LOW_BIT = 0;
  localparam int MODE_HIGH_BIT = 1;
  localparam int DISCH_BIT = 0;
  localparam int PG_BIT = 0;
  localparam int EVT_INPUT_UNDERVOLT_LOCKOUT = 0;
  localparam int EVT_SHORT = 1;
  localparam int EVT_OCP = 2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_HIGH = 8'h00;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_DISCH = 8'h01;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_PEAK_CURRENT_LIMIT = 8'h00;
  localparam logic [7:0] RST_GRP = 8'h00;
  // Bus address, value arbitrary
  localparam logic [6:0] I2C_ADDR = 7'h2A;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } bcp_wr_t;
  typedef struct packed {
    logic on;
    logic forced;
    logic [6:0] code;
    logic [1:0] group;
  } bcp_preset_t;
  typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_SHORT, ST_HOT} bcp_state_t;
  typedef enum logic [1:0] {SW_IDLE, SW_HIGH, SW_LOW, SW_SKIP} bcp_sw_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA} bcp_i2c_t;
endpackage

// *** rtl/bcp_top.sv ***
// Buck converter control, protection and register file
// Function
// - Two presets held; preset pin picks one after its two-flop synchroniser.
// - Per-preset mode bit: auto moves to pulse skipping, forced stays fixed.
// - Fixed-frequency: high side on at each switching tick, off after duty.
// - Low side on until next tick when forced; auto ends it on zero current.
// - Zero current in skip mode: low side off, sleep until output low.
// - End of skip: high side on until minimum peak current reached.
// - Separate software turn-on bit for each preset.
// - Reference ramps one code per 10 us toward a new target once soft start is over.
// - Discharge at shutdown when discharge bit set; bit defaults active.
// - Output good flag follows power good comparator.
// - Soft start when power input good; shut down when it drops.
// - Sticky input undervoltage flag, cleared by bus or supply reset.
// - After soft start, output below half target shuts off and retries.
// - Latch released by power input, pin or bus re-enable; short flag set.
// - Overcurrent withholds next high-side pulse; two-bit limit field.
// - Sticky overcurrent flag, cleared by bus or supply reset.
// - Overtemperature latches off until temperature falls.
// - Short: retry after 4 ms; failed within 1 ms repeats cycle.
// - Short before turn-on failing within 1 ms retries 4 ms later.
// - Runs only with turn-on pin high and selected on bit set.
// - Preset pin low uses low preset fields, high uses high.
// - Pin toggle or supply reset clears protection latch.
`timescale 1ns/1ps
`default_nettype none
module bcp_top import bcp_pkg::*; #(
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int START_CYCLES = START_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic preset_select_pin,
  input wire logic enable_pin,
  input wire logic power_input_ok,
  input wire logic out_good_cmp,
  input wire logic out_half_cmp,
  input wire logic out_low_cmp,
  input wire logic zero_current_detect,
  input wire logic min_peak_cmp,
  input wire logic overcurrent_cmp,
  input wire logic duty_end_cmp,
  input wire logic over_temp_cmp,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic high_side_on,
  output logic low_side_on,
  output logic discharge_on,
  output logic skip_sleep,
  output logic running,
  output logic [6:0] ref_code,
  output logic [1:0] range_group,
  output logic [1:0] peak_limit_level
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;

  assign pin_raw = {preset_select_pin, enable_pin, power_input_ok,
    out_good_cmp, out_half_cmp, out_low_cmp, zero_current_detect,
    min_peak_cmp, overcurrent_cmp, duty_end_cmp, over_temp_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic sel_s;
  logic en_s;
  logic pwr_s;
  logic good_s;
  logic half_s;
  logic low_s;
  logic zc_s;
  logic minpk_s;
  logic oc_s;
  logic duty_s;
  logic hot_s;
  assign {sel_s, en_s, pwr_s, good_s, half_s, low_s, zc_s,
    minpk_s, oc_s, duty_s, hot_s} = pin_s2;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  bcp_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] high_set;
  logic [7:0] low_set;
  logic [7:0] disch_reg;
  logic [7:0] mode_reg;
  logic [7:0] peak_current_limit_reg;
  logic [7:0] grp_high;
  logic [7:0] grp_low;
  logic [2:0] evt;
  logic [2:0] evt_set;

  bcp_i2c_slave u_i2c (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Only the supply reset clears settings; turning off keeps them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      high_set <= RST_HIGH;
      low_set <= RST_LOW;
      disch_reg <= RST_DISCH;
      mode_reg <= RST_MODE;
      peak_current_limit_reg <= RST_PEAK_CURRENT_LIMIT;
      grp_high <= RST_GRP;
      grp_low <= RST_GRP;
    end else if (wr.en) begin
      if (wr.addr == REG_HIGH) begin
        high_set <= wr.data;
      end else if (wr.addr == REG_LOW) begin
        low_set <= wr.data;
      end else if (wr.addr == REG_DISCH) begin
        disch_reg <= {7'h00, wr.data[DISCH_BIT]};
      end else if (wr.addr == REG_MODE) begin
        mode_reg <= {6'h00, wr.data[1:0]};
      end else if (wr.addr == REG_PEAK_CURRENT_LIMIT) begin
        peak_current_limit_reg <= {6'h00, wr.data[1:0]};
      end else if (wr.addr == REG_GRP_HIGH) begin
        grp_high <= {6'h00, wr.data[1:0]};
      end else if (wr.addr == REG_GRP_LOW) begin
        grp_low <= {6'h00, wr.data[1:0]};
      end
    end
  end

  // Sticky events: a set in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evt <= 3'h0;
    end else if (wr.en && wr.addr == REG_EVT) begin
      evt <= (evt & ~wr.data[2:0]) | evt_set;
    end else begin
      evt <= evt | evt_set;
    end
  end

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_PG) begin
      v[PG_BIT] = good_s;
    end else if (a == REG_HIGH) begin
      v = high_set;
    end else if (a == REG_LOW) begin
      v = low_set;
    end else if (a == REG_DISCH) begin
      v = disch_reg;
    end else if (a == REG_MODE) begin
      v = mode_reg;
    end else if (a == REG_PEAK_CURRENT_LIMIT) begin
      v = peak_current_limit_reg;
    end else if (a == REG_EVT) begin
      v = {5'h00, evt};
    end else if (a == REG_GRP_HIGH) begin
      v = grp_high;
    end else if (a == REG_GRP_LOW) begin
      v = grp_low;
    end
    return v;
  endfunction

  always_comb rd_data = reg_read(rd_addr);

  // ----------------------------------------
  // Preset selection
  // ----------------------------------------
  bcp_preset_t sel;
  always_comb begin
    if (sel_s) begin
      sel.on = high_set[ON_BIT];
      sel.forced = mode_reg[MODE_HIGH_BIT];
      sel.code = high_set[6:0];
      sel.group = grp_high[1:0];
    end else begin
      sel.on = low_set[ON_BIT];
      sel.forced = mode_reg[MODE_LOW_BIT];
      sel.code = low_set[6:0];
      sel.group = grp_low[1:0];
    end
  end

  // Pin and the chosen on bit are both needed; pin alone does nothing
  logic go;
  assign go = en_s && sel.on && pwr_s;

  // ----------------------------------------
  // Converter sequencing
  // ----------------------------------------
  bcp_state_t state;
  logic [15:0] tmr;
  logic pwr_d;
  logic at_target;
  assign at_target = (ref_code == sel.code);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_d <= 1'b0;
    end else begin
      pwr_d <= pwr_s;
    end
  end

  always_comb begin
    evt_set = 3'h0;
    evt_set[EVT_INPUT_UNDERVOLT_LOCKOUT] = pwr_d && !pwr_s && state != ST_OFF;
    evt_set[EVT_OCP] = oc_s && (state == ST_SOFT || state == ST_RUN);
    evt_set[EVT_SHORT] = (state == ST_RUN && half_s) ||
      (state == ST_SOFT && tmr == 16'(START_CYCLES - 1));
  end

  // Dropping go (pin toggle, bus disable, power input loss) clears latches
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_OFF;
      tmr <= 16'h0000;
    end else if (!go) begin
      state <= ST_OFF;
      tmr <= 16'h0000;
    end else begin
      case (state)
        ST_OFF: begin
          tmr <= 16'h0000;
          if (!hot_s) begin
            state <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          tmr <= tmr + 16'h0001;
          if (hot_s) begin
            state <= ST_HOT;
          end else if (at_target && good_s) begin
            state <= ST_RUN;
          end else if (tmr == 16'(START_CYCLES - 1)) begin
            state <= ST_SHORT;
            tmr <= 16'h0000;
          end
        end
        ST_RUN: begin
          if (hot_s) begin
            state <= ST_HOT;
          end else if (half_s) begin
            state <= ST_SHORT;
            tmr <= 16'h0000;
          end
        end
        ST_SHORT: begin
          tmr <= tmr + 16'h0001;
          if (hot_s) begin
            state <= ST_HOT;
          end else if (tmr == 16'(RETRY_CYCLES - 1)) begin
            state <= ST_SOFT;
            tmr <= 16'h0000;
          end
        end
        ST_HOT: begin
          if (!hot_s) begin
            state <= ST_OFF;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  logic active;
  assign active = (state == ST_SOFT || state == ST_RUN);

  // ----------------------------------------
  // Reference ramp
  // ----------------------------------------
  // Soft start steps faster so a full ramp fits in the start window
  logic [6:0] rcnt;
  logic rstep;
  assign rstep = (state == ST_SOFT) ? (rcnt >= 7'(SOFT_STEP_CYC - 1))
                                    : (rcnt == 7'(RAMP_STEP_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_code <= 7'h00;
      rcnt <= 7'h00;
    end else if (!active) begin
      ref_code <= 7'h00;
      rcnt <= 7'h00;
    end else if (rstep) begin
      rcnt <= 7'h00;
      if (ref_code < sel.code) begin
        ref_code <= ref_code + 7'h01;
      end else if (ref_code > sel.code) begin
        ref_code <= ref_code - 7'h01;
      end
    end else begin
      rcnt <= rcnt + 7'h01;
    end
  end

  // ----------------------------------------
  // Switching clock and power switches
  // ----------------------------------------
  logic [1:0] scnt;
  logic tick;
  assign tick = (scnt == 2'(SW_PERIOD_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scnt <= 2'h0;
    end else if (tick) begin
      scnt <= 2'h0;
    end else begin
      scnt <= scnt + 2'h1;
    end
  end

  bcp_sw_t ph;
  logic minpk_mode;
  logic hs_end;
  assign hs_end = minpk_mode ? (minpk_s || oc_s) : (duty_s || oc_s);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph <= SW_IDLE;
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
      skip_sleep <= 1'b0;
      minpk_mode <= 1'b0;
    end else if (!active) begin
      ph <= SW_IDLE;
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
      skip_sleep <= 1'b0;
      minpk_mode <= 1'b0;
    end else begin
      case (ph)
        SW_IDLE: begin
          if (tick && !oc_s) begin
            ph <= SW_HIGH;
            high_side_on <= 1'b1;
          end
        end
        SW_HIGH: begin
          if (hs_end) begin
            ph <= SW_LOW;
            high_side_on <= 1'b0;
            low_side_on <= 1'b1;
            minpk_mode <= 1'b0;
          end
        end
        SW_LOW: begin
          if (!sel.forced && zc_s) begin
            ph <= SW_SKIP;
            low_side_on <= 1'b0;
            skip_sleep <= 1'b1;
          end else if (tick) begin
            low_side_on <= 1'b0;
            if (!oc_s) begin
              ph <= SW_HIGH;
              high_side_on <= 1'b1;
            end else begin
              ph <= SW_IDLE;
            end
          end
        end
        SW_SKIP: begin
          if (sel.forced) begin
            ph <= SW_IDLE;
            skip_sleep <= 1'b0;
          end else if (low_s && !oc_s) begin
            ph <= SW_HIGH;
            high_side_on <= 1'b1;
            skip_sleep <= 1'b0;
            minpk_mode <= 1'b1;
          end
        end
        default: ph <= SW_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      discharge_on <= 1'b0;
      running <= 1'b0;
      range_group <= 2'h0;
      peak_limit_level <= 2'h0;
    end else begin
      discharge_on <= !active && disch_reg[DISCH_BIT];
      running <= active;
      range_group <= sel.group;
      peak_limit_level <= peak_current_limit_reg[1:0];
    end
  end
endmodule
`default_nettype wire

// *** tb/bcp_i2c_master.sv ***
// I2C bus master model that reaches the block's registers
`timescale 1ns/1ps
`default_nettype none
module bcp_i2c_master import bcp_pkg::*; (
  input wire logic mclk,
  input wire logic dev_pull,
  output logic scl,
  output logic sda
);
  logic rel = 1'b1;
  // Pull-up on the line: it only reads low while one party pulls it down
  assign sda = rel & ~dev_pull;
  initial scl = 1'b1;
  // Eight cycles per half bit keeps the device's synchronisers well fed
  task automatic hold();
    repeat (8) @(posedge mclk);
    #10;
  endtask
  task automatic clk_bit(input logic b, output logic r);
    rel = b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    rel = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    rel = 1'b0;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    rel = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    rel = 1'b1;
    hold();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, nack);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic nack);
    logic r;
    start();
    put_byte({dev, 1'b0}, nack);
    if (!nack) begin
      put_byte(a, r);
      put_byte(d, r);
    end
    stop();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    put_byte({I2C_ADDR, 1'b0}, r);
    put_byte(a, r);
    start();
    put_byte({I2C_ADDR, 1'b1}, r);
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// *** tb/bcp_top_assertions.sv ***
// Concurrent checks on the ports of the buck control block
`timescale 1ns/1ps
`default_nettype none
module bcp_assertions #(
  parameter int RETRY_CYCLES = 40,
  parameter int START_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable_pin,
  input wire logic power_input_ok,
  input wire logic overcurrent_cmp,
  input wire logic over_temp_cmp,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic skip_sleep,
  input wire logic running,
  input wire logic [6:0] ref_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Pins pass two flops, a state register and the running register, so five cycles covers the lag
  sequence s_en_low; !enable_pin [*5]; endsequence
  sequence s_pwr_low; !power_input_ok [*5]; endsequence
  sequence s_hot; over_temp_cmp [*5]; endsequence
  sequence s_oc_held; overcurrent_cmp [*4]; endsequence
  property p_en; s_en_low |-> !running; endproperty
  a_en: assert property (p_en) else $error("converter runs with turn-on pin low");
  property p_pwr; s_pwr_low |-> !running; endproperty
  a_pwr: assert property (p_pwr) else $error("converter runs without power input");
  property p_hot; s_hot |-> !running; endproperty
  a_hot: assert property (p_hot) else $error("converter runs while over temperature");
  property p_oc; s_oc_held |-> !high_side_on; endproperty
  a_oc: assert property (p_oc) else $error("high side on during overcurrent");
  property p_excl; !(high_side_on && low_side_on); endproperty
  a_excl: assert property (p_excl) else $error("both switches on");
  property p_skip; skip_sleep |-> !high_side_on && !low_side_on; endproperty
  a_skip: assert property (p_skip) else $error("switch on while skipping");
  property p_step;
    running && $past(running) && $changed(ref_code) |->
      (ref_code == $past(ref_code) + 7'h01) || (ref_code == $past(ref_code) - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("reference jumped");
  property p_gap; running && $changed(ref_code) |=> (!running || $stable(ref_code)) [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("reference stepped too fast");
  cover property (running && skip_sleep);
endmodule
bind bcp_top bcp_assertions #(.RETRY_CYCLES(RETRY_CYCLES), .START_CYCLES(START_CYCLES)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .enable_pin(enable_pin), .power_input_ok(power_input_ok),
  .overcurrent_cmp(overcurrent_cmp), .over_temp_cmp(over_temp_cmp),
  .high_side_on(high_side_on), .low_side_on(low_side_on), .skip_sleep(skip_sleep),
  .running(running), .ref_code(ref_code));
`default_nettype wire

// *** tb/bcp_top_test.sv ***
// Register-level testbench of the buck control block
`timescale 1ns/1ps
`default_nettype none
module bcp_top_test import bcp_pkg::*; ;
  logic mclk, rst_n, psel, en, pwr_ok, good, half, low_out, zc, oc, hot;
  logic minpk = 1'b1;
  logic duty = 1'b1;
  logic scl, sda, sda_oe, high_side_on, low_side_on, discharge_on, skip_sleep, running, nk;
  logic [6:0] ref_code, tgt;
  logic [1:0] range_group, peak_limit_level;
  logic [7:0] rd;
  int failures = 0;
  int total_checks = 0;
  int n;
  logic [7:0] regs [10] = '{REG_PG, REG_HIGH, REG_LOW, REG_DISCH, REG_MODE, REG_PEAK_CURRENT_LIMIT, REG_EVT,
                            REG_GRP_HIGH, REG_GRP_LOW, 8'h20};
  logic [7:0] rvals [10] = '{8'h00, RST_HIGH, RST_LOW, RST_DISCH, RST_MODE, RST_PEAK_CURRENT_LIMIT, 8'h00,
                             RST_GRP, RST_GRP, 8'h00};
  // Short retry and start counts keep the run brief
  bcp_top #(.RETRY_CYCLES(40), .START_CYCLES(200)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .preset_select_pin(psel), .enable_pin(en),
    .power_input_ok(pwr_ok), .out_good_cmp(good), .out_half_cmp(half), .out_low_cmp(low_out),
    .zero_current_detect(zc), .min_peak_cmp(minpk), .overcurrent_cmp(oc), .duty_end_cmp(duty),
    .over_temp_cmp(hot), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .high_side_on(high_side_on), .low_side_on(low_side_on), .discharge_on(discharge_on),
    .skip_sleep(skip_sleep), .running(running), .ref_code(ref_code), .range_group(range_group),
    .peak_limit_level(peak_limit_level));
  bcp_i2c_master master_u (.mclk(mclk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #10;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return running;
      1: return skip_sleep;
      2: return high_side_on;
      default: return ref_code === tgt;
    endcase
  endfunction
  // Counts cycles until probe k shows v; running out of patience ends the run
  task automatic wait_for(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (probe(k) !== v) begin
      if (c == lim) begin
        chk($sformatf("wait %0d", k), probe(k), v);
        report_and_stop();
      end
      tick(1);
      c++;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    {psel, en, good, half, low_out, zc, oc, hot} = 8'h00;
    pwr_ok = 1'b1;
    tgt = 7'h00;
    tick(8);
    rst_n = 1'b1;
    tick(3);
    for (int i = 0; i < 10; i++) begin
      master_u.read_reg(regs[i], rd);
      chk("register", rd, rvals[i]);
    end
    chk("discharge", discharge_on, 1'b1);
    master_u.write_reg(I2C_ADDR ^ 7'h01, REG_PEAK_CURRENT_LIMIT, 8'h02, nk);
    chk("foreign address ack", nk, 1'b1);
    master_u.write_reg(I2C_ADDR, REG_PEAK_CURRENT_LIMIT, 8'h03, nk);
    master_u.read_reg(REG_PEAK_CURRENT_LIMIT, rd);
    chk("peak limit reg", rd, 8'h03);
    chk("peak limit out", peak_limit_level, 2'b11);
    master_u.write_reg(I2C_ADDR, REG_GRP_HIGH, 8'h02, nk);
    master_u.write_reg(I2C_ADDR, REG_GRP_LOW, 8'h02, nk);
    $display("test registers done");
    en = 1'b1;
    tick(20);
    chk("running without on bit", running, 1'b0);
    master_u.write_reg(I2C_ADDR, REG_LOW, 8'h85, nk);
    wait_for(0, 1'b1, 100, n);
    good = 1'b1;
    tgt = 7'h05;
    wait_for(3, 1'b1, 200, n);
    master_u.read_reg(REG_PG, rd);
    chk("output good", rd, 8'h01);
    chk("discharge while on", discharge_on, 1'b0);
    $display("test enable done");
    master_u.write_reg(I2C_ADDR, REG_HIGH, 8'h8A, nk);
    master_u.write_reg(I2C_ADDR, REG_MODE, 8'h02, nk);
    psel = 1'b1;
    tgt = 7'h0A;
    wait_for(3, 1'b1, 2000, n);
    chk("ramp slow", n >= 400, 1'b1);
    chk("range group", range_group, 2'b10);
    zc = 1'b1;
    tick(30);
    chk("forced skip", skip_sleep, 1'b0);
    duty = 1'b0;
    tick(6);
    chk("duty hold", high_side_on, 1'b1);
    duty = 1'b1;
    zc = 1'b0;
    psel = 1'b0;
    tgt = 7'h05;
    wait_for(3, 1'b1, 2000, n);
    zc = 1'b1;
    wait_for(1, 1'b1, 50, n);
    chk("low side in skip", low_side_on, 1'b0);
    zc = 1'b0;
    minpk = 1'b0;
    low_out = 1'b1;
    wait_for(2, 1'b1, 30, n);
    tick(6);
    chk("min peak hold", high_side_on, 1'b1);
    minpk = 1'b1;
    low_out = 1'b0;
    $display("test presets done");
    oc = 1'b1;
    tick(20);
    chk("high side in overcurrent", high_side_on, 1'b0);
    oc = 1'b0;
    master_u.read_reg(REG_EVT, rd);
    chk("overcurrent flag", rd[EVT_OCP], 1'b1);
    master_u.write_reg(I2C_ADDR, REG_EVT, 8'h04, nk);
    master_u.read_reg(REG_EVT, rd);
    chk("flags cleared", rd, 8'h00);
    $display("test overcurrent done");
    half = 1'b1;
    wait_for(0, 1'b0, 20, n);
    half = 1'b0;
    wait_for(0, 1'b1, 200, n);
    chk("retry delay", n >= 36 && n <= 48, 1'b1);
    master_u.read_reg(REG_EVT, rd);
    chk("short flag", rd[EVT_SHORT], 1'b1);
    good = 1'b0;
    en = 1'b0;
    tick(5);
    en = 1'b1;
    wait_for(0, 1'b1, 20, n);
    wait_for(0, 1'b0, 400, n);
    chk("start limit", n >= 190 && n <= 210, 1'b1);
    good = 1'b1;
    wait_for(0, 1'b1, 100, n);
    chk("start retry delay", n >= 36 && n <= 48, 1'b1);
    $display("test short done");
    pwr_ok = 1'b0;
    wait_for(0, 1'b0, 10, n);
    master_u.read_reg(REG_EVT, rd);
    chk("undervolt flag", rd[EVT_INPUT_UNDERVOLT_LOCKOUT], 1'b1);
    pwr_ok = 1'b1;
    wait_for(0, 1'b1, 20, n);
    master_u.write_reg(I2C_ADDR, REG_EVT, 8'h07, nk);
    master_u.read_reg(REG_EVT, rd);
    chk("all flags cleared", rd, 8'h00);
    hot = 1'b1;
    wait_for(0, 1'b0, 10, n);
    tick(50);
    chk("hot stays off", running, 1'b0);
    hot = 1'b0;
    wait_for(0, 1'b1, 20, n);
    en = 1'b0;
    wait_for(0, 1'b0, 10, n);
    tick(3);
    chk("discharge when off", discharge_on, 1'b1);
    master_u.read_reg(REG_PEAK_CURRENT_LIMIT, rd);
    chk("kept while off", rd, 8'h03);
    master_u.write_reg(I2C_ADDR, REG_DISCH, 8'h00, nk);
    chk("discharge off", discharge_on, 1'b0);
    $display("test protection done");
    report_and_stop();
  end
endmodule
`default_nettype wire
